// *** inc/lsi_pkg.sv ***
// Package for the link status and interrupt register bank.
// Assumes a 32-bit APB slave on a single 10 MHz clock.
package lsi_pkg;
	// ---------------------------------------------
	// Register byte addresses
	// ---------------------------------------------
	localparam logic [7:0] LSI_ADDR_ACK_PTR = 8'h00;
	localparam logic [7:0] LSI_ADDR_EVT_SEQ = 8'h04;
	localparam logic [7:0] LSI_ADDR_LINK_LINE = 8'h08;
	localparam logic [7:0] LSI_ADDR_IRQ_ENABLE = 8'h0c;
	localparam logic [7:0] LSI_ADDR_IRQ_CLEAR = 8'h10;
	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int LSI_ACK_LO = 5;
	localparam int LSI_PNR_BIT = 4;
	localparam int LSI_NTX_LO = 1;
	localparam int LSI_LNR_BIT = 0;
	localparam int LSI_PKT_BIT = 7;
	localparam int LSI_ACKED_BIT = 6;
	localparam int LSI_ERR_BIT = 5;
	localparam int LSI_SEQ_LO = 1;
	localparam int LSI_TMO_BIT = 7;
	localparam int LSI_SREQ_BIT = 6;
	localparam int LSI_IDLE_BIT = 5;
	localparam int LSI_LINK_BIT = 0;
	localparam int LSI_EVT_LO = 5;
	// ---------------------------------------------
	// Widths and values
	// ---------------------------------------------
	localparam int LSI_SEQ_W = 3;
	localparam int LSI_EVT_W = 3;
	localparam logic [2:0] LSI_EVT_ALL = 3'h7;
	localparam logic [2:0] LSI_SEQ_ONE = 3'h1;
	localparam int LSI_IDLE_ONES = 15;
	localparam logic [4:0] LSI_IDLE_CNT_ZERO = 5'h00;
	localparam logic [4:0] LSI_IDLE_CNT_ONE = 5'h01;
	localparam logic [31:0] LSI_ZERO_WORD = 32'h0000_0000;
endpackage : lsi_pkg

// *** verif/lsi_host.sv ***
// Host model: APB master, one transfer per call.
// Assumes the slave answers with pready some cycles after setup.
`timescale 1ns/1ps
module lsi_host (
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in, pslverr_in,
	output logic psel_out, penable_out, pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out
);
	initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
	// Request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		// No cycle limit here: only the bench timeout ends a wait
		do begin
			@(posedge clk_in);
		end while (pready_in !== 1'b1);
		r = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
	endtask : xfer
endmodule : lsi_host

// *** verif/lsi_props_properties.sv ***
// Port checker for the status bank.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ps
module lsi_props
	import lsi_pkg::*;
(
	input wire logic clk_in, rst_in, clk_en_in, psel_in, penable_in, pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic good_packet_in, blocks_acked_in, error_event_in,
	input wire logic timer_timeout_in, timer_restart_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out, pslverr_out, retry_timer_run_out, interrupt_request_n_out,
	input wire logic [2:0] expected_seq_number_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Setup phase while running
	wire logic setup = clk_en_in && psel_in && !penable_in;
	wire logic evt = good_packet_in || blocks_acked_in || error_event_in;
	a_apb_answer: assert property (setup |=> pready_out ##1 !pready_out) else $error("no answer");
	a_unmapped_err: assert property (setup && !pwrite_in && paddr_in > 8'h10
		|=> pslverr_out && prdata_out == LSI_ZERO_WORD) else $error("unmapped");
	a_read_clear: assert property (setup && !pwrite_in && paddr_in == LSI_ADDR_EVT_SEQ && !evt
		|=> interrupt_request_n_out) else $error("irq kept");
	a_rdata_hold: assert property (!(setup && !pwrite_in) |=> $stable(prdata_out))
		else $error("rdata moved");
	a_seq_step: assert property (clk_en_in && good_packet_in |=> expected_seq_number_out
		== $past(expected_seq_number_out) + LSI_SEQ_ONE) else $error("seq step");
	a_seq_hold: assert property (!(clk_en_in && good_packet_in)
		|=> $stable(expected_seq_number_out)) else $error("seq moved");
	a_timer_stop: assert property (clk_en_in && timer_timeout_in && !timer_restart_in
		|=> !retry_timer_run_out) else $error("timer runs");
	a_timer_start: assert property (clk_en_in && timer_restart_in |=> retry_timer_run_out)
		else $error("timer idle");
endmodule : lsi_props
bind lsi_status_irq lsi_props u_props (.*);

// *** verif/testbench.sv ***
// Self-checking bench for the status and interrupt bank.
// Assumes the host model on APB and bench-driven link events.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t value mismatch", $time); end end
module testbench
	import lsi_pkg::*;
;
	logic clk_in = 0, rst_in = 1, clk_en_in = 1, rx_line_in = 0;
	logic local_nr = 0, link_up = 0, tx_att = 0, psel, penable, pwrite, pready, pslverr;
	logic irq_n, run, e;
	logic [2:0] ack_ptr = 0, ntx = 0, seq;
	logic [6:0] ev = 0;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int n_fail = 0, tests_run = 0, cyc = 0;
	always #50 clk_in = ~clk_in;
	lsi_status_irq dut (.clk_in, .rst_in, .clk_en_in, .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .rnr_rx_in(ev[0]),
		.ready_frame_rx_in(ev[1]), .local_not_ready_in(local_nr), .ack_pointer_in(ack_ptr),
		.next_tx_block_in(ntx), .good_packet_in(ev[2]), .blocks_acked_in(ev[3]),
		.error_event_in(ev[4]), .link_up_in(link_up), .tx_attempt_in(tx_att),
		.timer_timeout_in(ev[5]), .timer_restart_in(ev[6]), .rx_line_in,
		.expected_seq_number_out(seq), .retry_timer_run_out(run),
		.interrupt_request_n_out(irq_n));
	lsi_host host (.clk_in, .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
		.psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
		.pwdata_out(pwdata));
	task automatic pulse(input logic [6:0] m);
		@(posedge clk_in);
		ev <= m;
		@(posedge clk_in);
		ev <= '0;
	endtask : pulse
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		host.xfer(1'b0, a, '0, r, e);
		`CHK(r, 32'(x))
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, r, e);
	endtask : wr
	task automatic irq_is(input logic x);
		@(posedge clk_in);
		#1;
		`CHK(irq_n, x)
	endtask : irq_is
	task automatic t_reset();
		rd(LSI_ADDR_ACK_PTR, 8'h00);
		rd(LSI_ADDR_EVT_SEQ, 8'h00);
		rd(LSI_ADDR_LINK_LINE, 8'h01);
		rd(LSI_ADDR_IRQ_ENABLE, 8'h07);
		rd(8'h14, 8'h00);
		`CHK(e, 1'b1)
		`CHK(irq_n, 1'b1)
	endtask : t_reset
	task automatic t_ptr();
		ack_ptr <= 3'h5;
		ntx <= 3'h3;
		local_nr <= 1'b1;
		pulse(7'h01);
		rd(LSI_ADDR_ACK_PTR, 8'hb7);
		pulse(7'h03);
		wr(LSI_ADDR_ACK_PTR, 32'hffff_ffff);
		rd(LSI_ADDR_ACK_PTR, 8'hb7);
		pulse(7'h02);
		rd(LSI_ADDR_ACK_PTR, 8'ha7);
	endtask : t_ptr
	task automatic t_events();
		pulse(7'h04);
		irq_is(1'b0);
		`CHK(seq, 3'h1)
		rd(LSI_ADDR_EVT_SEQ, 8'h82);
		irq_is(1'b1);
		rd(LSI_ADDR_EVT_SEQ, 8'h02);
		pulse(7'h18);
		irq_is(1'b0);
		rd(LSI_ADDR_EVT_SEQ, 8'h62);
		clk_en_in <= 1'b0;
		pulse(7'h04);
		clk_en_in <= 1'b1;
		rd(LSI_ADDR_EVT_SEQ, 8'h02);
	endtask : t_events
	task automatic t_mask();
		wr(LSI_ADDR_IRQ_ENABLE, 32'h0);
		pulse(7'h10);
		irq_is(1'b1);
		wr(LSI_ADDR_IRQ_CLEAR, 32'h1);
		wr(LSI_ADDR_IRQ_ENABLE, 32'h7);
		irq_is(1'b1);
		rd(LSI_ADDR_EVT_SEQ, 8'h02);
	endtask : t_mask
	task automatic t_link();
		link_up <= 1'b1;
		tx_att <= 1'b1;
		rx_line_in <= 1'b1;
		pulse(7'h40);
		pulse(7'h20);
		repeat (25) @(posedge clk_in);
		rd(LSI_ADDR_LINK_LINE, 8'he0);
		`CHK(run, 1'b0)
		pulse(7'h40);
		rx_line_in <= 1'b0;
		repeat (25) @(posedge clk_in);
		rd(LSI_ADDR_LINK_LINE, 8'h40);
		`CHK(run, 1'b1)
	endtask : t_link
	task automatic summarize();
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// Hang guard, far above the expected run length
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_ptr();
		t_events();
		t_mask();
		t_link();
		summarize();
	end
endmodule : testbench

// *** verilog/lsi_status_irq.sv ***
// Status bytes, event flags and interrupt request of the link controller,
// with a small APB register port for the host.
// Assumes frame logic delivers one-cycle event pulses and sequence values
// on clk_in, and the receive line arrives asynchronously on a pin.
// Assumes the host reads the event byte to acknowledge each interrupt.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps

// Behaviour
// - Peer-not-ready set by RNR frame, cleared by RR, REJ, SABM or UA.
// - Top three bits of first status byte show next block awaiting ack.
// - Error/event flag set on unrecoverable error or significant link event.
// - Interrupt request low while any enabled event flag is set.
// - Reading second status byte clears all event flags, interrupt returns high.
// - Link-state bit reads 0 when link established, 1 when disconnected.
// - Send-request bit set while transmitter attempts to send data or flags.
// - Timer-expired bit set on timeout, timer stopped, cleared on restart.
module lsi_status_irq
	import lsi_pkg::*;
#(
	parameter int IDLE_ONES = LSI_IDLE_ONES
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Frame events (one-cycle pulses) and status levels from link logic
	input wire logic rnr_rx_in,
	input wire logic ready_frame_rx_in,
	input wire logic local_not_ready_in,
	input wire logic [2:0] ack_pointer_in,
	input wire logic [2:0] next_tx_block_in,
	input wire logic good_packet_in,
	input wire logic blocks_acked_in,
	input wire logic error_event_in,
	input wire logic link_up_in,
	input wire logic tx_attempt_in,
	input wire logic timer_timeout_in,
	input wire logic timer_restart_in,
	// Receive line pin
	input wire logic rx_line_in,
	// Status to link logic and host
	output logic [2:0] expected_seq_number_out,
	output logic retry_timer_run_out,
	output logic interrupt_request_n_out
);
	// ---------------------------------------------
	// State
	// ---------------------------------------------
	// Every register below holds still while clk_en_in is low, the bus port
	// included, so a frozen block keeps its stored flags, drops event pulses arriving meanwhile
	// and answers no transfer; the host must not expect progress meanwhile.
	// Status state
	logic peer_not_ready_flag;
	logic [2:0] event_flags;
	logic [2:0] expected_seq_number;
	logic retry_timer_expired;
	logic internal_send_request;
	logic link_down;
	logic receiver_idle_flag;
	logic [2:0] irq_enable;
	logic [2:0] rx_sync;
	logic [4:0] ones_count;
	logic [2:0] ack_pointer;
	logic [2:0] next_tx_block;
	logic local_not_ready_sent;

	// Bus decode and byte assembly
	logic rd_access;
	logic wr_access;
	logic evt_read;
	logic addr_ok;
	logic [2:0] evt_set;
	logic [2:0] evt_clr;
	logic [7:0] byte_ack;
	logic [7:0] byte_evt;
	logic [7:0] byte_link;
	logic [31:0] next_prdata;
	logic enable_write;
	logic clear_write;
	logic rx_agree;
	logic rx_level;

	// Access strobes, taken in the setup cycle so the answer is one cycle;
	// a low clock enable refuses the access along with everything else
	assign rd_access = psel_in & ~penable_in & ~pwrite_in & clk_en_in;
	assign wr_access = psel_in & ~penable_in & pwrite_in & clk_en_in;
	assign evt_read = rd_access & (paddr_in == LSI_ADDR_EVT_SEQ);
	// Control register writes, decoded once for the enable and clear paths
	assign enable_write = wr_access & (paddr_in == LSI_ADDR_IRQ_ENABLE);
	assign clear_write = wr_access & (paddr_in == LSI_ADDR_IRQ_CLEAR);

	// Event set vector in register bit order
	assign evt_set = {good_packet_in, blocks_acked_in, error_event_in};
	// software clear by read; the clear register drops single bits
	assign evt_clr = (evt_read ? LSI_EVT_ALL : 3'h0)
		| (clear_write ? pwdata_in[2:0] : 3'h0);

	// ---------------------------------------------
	// Peer busy and pointers
	// ---------------------------------------------
	// peer busy latch
	// A busy frame and a ready frame in one cycle leave the peer busy
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			peer_not_ready_flag <= 1'b0;
		end else if (clk_en_in) begin
			if (rnr_rx_in) begin
				peer_not_ready_flag <= 1'b1;
			end else if (ready_frame_rx_in) begin
				peer_not_ready_flag <= 1'b0;
			end
		end
	end

	// pointer capture
	// Sampled every cycle; status byte 0 lags the link logic by one cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_pointer <= 3'h0;
			next_tx_block <= 3'h0;
		end else if (clk_en_in) begin
			ack_pointer <= ack_pointer_in;
			next_tx_block <= next_tx_block_in;
		end
	end

	// Local busy indication, copied for the host
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			local_not_ready_sent <= 1'b0;
		end else if (clk_en_in) begin
			local_not_ready_sent <= local_not_ready_in;
		end
	end

	// ---------------------------------------------
	// Event flags
	// ---------------------------------------------
	// sticky flags, one flop per event bit; a set in the clear cycle wins
	// so an event landing on the read edge is kept for the next read
	for (genvar i = 0; i < LSI_EVT_W; i++) begin : g_evt_flag
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				event_flags[i] <= 1'b0;
			end else if (clk_en_in) begin
				if (evt_set[i]) begin
					event_flags[i] <= 1'b1;
				end else if (evt_clr[i]) begin
					event_flags[i] <= 1'b0;
				end
			end
		end
	end

	// expected number advances per good packet
	// Wraps modulo eight like the frame sequence counters
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			expected_seq_number <= 3'h0;
		end else if (clk_en_in && good_packet_in) begin
			expected_seq_number <= expected_seq_number + LSI_SEQ_ONE;
		end
	end

	// Interrupt enables, all on after reset for plain flag behaviour;
	// masked events still set their flags, only the request pin is gated
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_enable <= LSI_EVT_ALL;
		end else if (enable_write) begin
			irq_enable <= pwdata_in[2:0];
		end
	end

	// active-low request from registered flags
	// Built from the next flag value so the pin moves with the flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			interrupt_request_n_out <= 1'b1;
		end else if (clk_en_in) begin
			interrupt_request_n_out <= ~|(((event_flags & ~evt_clr) | evt_set) & irq_enable);
		end
	end

	// ---------------------------------------------
	// Link and line state
	// ---------------------------------------------
	// link-state bit is inverted sense: set while the link is down
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			link_down <= 1'b1;
		end else if (clk_en_in) begin
			link_down <= ~link_up_in;
		end
	end

	// send request follows transmitter attempts, successful or not
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			internal_send_request <= 1'b0;
		end else if (clk_en_in) begin
			internal_send_request <= tx_attempt_in;
		end
	end

	// timeout stops timer until restart
	// Restart beats a timeout in the same cycle; the run output feeds the timer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			retry_timer_expired <= 1'b0;
			retry_timer_run_out <= 1'b0;
		end else if (clk_en_in) begin
			if (timer_restart_in) begin
				retry_timer_expired <= 1'b0;
				retry_timer_run_out <= 1'b1;
			end else if (timer_timeout_in) begin
				retry_timer_expired <= 1'b1;
				retry_timer_run_out <= 1'b0;
			end
		end
	end

	// Three-stage synchroniser for the receive pin
	// The first stage may go metastable; only the later stages are trusted
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx_sync <= 3'h0;
		end else if (clk_en_in) begin
			rx_sync <= {rx_sync[1:0], rx_line_in};
		end
	end

	// Settled receive level: a change counts once stages two and three agree
	assign rx_agree = (rx_sync[1] == rx_sync[2]);
	assign rx_level = rx_sync[2];

	// idle after run of ones; counts clock samples, not bit times
	// Limitation: one clock sample stands for one line bit here, so a faster
	// clock than the line needs a larger IDLE_ONES to keep the same meaning
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ones_count <= LSI_IDLE_CNT_ZERO;
			receiver_idle_flag <= 1'b0;
		end else if (clk_en_in && rx_agree) begin
			if (!rx_level) begin
				ones_count <= LSI_IDLE_CNT_ZERO;
				receiver_idle_flag <= 1'b0;
			end else if (ones_count < 5'(IDLE_ONES)) begin
				ones_count <= ones_count + LSI_IDLE_CNT_ONE;
			end else begin
				receiver_idle_flag <= 1'b1;
			end
		end
	end

	// ---------------------------------------------
	// Read mux
	// ---------------------------------------------
	// Map: 0x00 pointers and peer busy, 0x04 events and expected number
	// (a read clears the events), 0x08 timer, send request, idle and link,
	// 0x0c interrupt enables, 0x10 write-one-to-clear for the events.
	// Writes to the status bytes are ignored without an error; unmapped
	// addresses answer with an error and zero data.

	// Pointer byte from named field positions
	always_comb begin
		byte_ack = 8'h00;
		byte_ack[LSI_ACK_LO +: LSI_SEQ_W] = ack_pointer;
		byte_ack[LSI_PNR_BIT] = peer_not_ready_flag;
		byte_ack[LSI_NTX_LO +: LSI_SEQ_W] = next_tx_block;
		byte_ack[LSI_LNR_BIT] = local_not_ready_sent;
	end

	// Event byte; the unused bits read 0
	always_comb begin
		byte_evt = 8'h00;
		byte_evt[LSI_EVT_LO +: LSI_EVT_W] = event_flags;
		byte_evt[LSI_SEQ_LO +: LSI_SEQ_W] = expected_seq_number;
	end

	// Timer, send request, idle and link bits; the middle bits read 0
	always_comb begin
		byte_link = 8'h00;
		byte_link[LSI_TMO_BIT] = retry_timer_expired;
		byte_link[LSI_SREQ_BIT] = internal_send_request;
		byte_link[LSI_IDLE_BIT] = receiver_idle_flag;
		byte_link[LSI_LINK_BIT] = link_down;
	end

	// Every mapped word, used for the error response
	assign addr_ok = (paddr_in == LSI_ADDR_ACK_PTR) || (paddr_in == LSI_ADDR_EVT_SEQ)
		|| (paddr_in == LSI_ADDR_LINK_LINE) || (paddr_in == LSI_ADDR_IRQ_ENABLE)
		|| (paddr_in == LSI_ADDR_IRQ_CLEAR);

	// Combinational read data selection
	always_comb begin
		next_prdata = LSI_ZERO_WORD;
		unique case (paddr_in)
			LSI_ADDR_ACK_PTR: next_prdata = {24'h0, byte_ack};
			LSI_ADDR_EVT_SEQ: next_prdata = {24'h0, byte_evt};
			LSI_ADDR_LINK_LINE: next_prdata = {24'h0, byte_link};
			LSI_ADDR_IRQ_ENABLE: next_prdata = {29'h0, irq_enable};
			default: next_prdata = LSI_ZERO_WORD;
		endcase
	end

	// APB answer: one wait-free access cycle after setup
	// A fixed one-cycle answer keeps the host simple; no wait states exist
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else if (clk_en_in) begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~addr_ok;
		end
	end

	// Read data captured at the setup edge and held until the next read
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prdata_out <= LSI_ZERO_WORD;
		end else if (rd_access) begin
			prdata_out <= next_prdata;
		end
	end

	// Sequence number to the receive side
	// Lookahead copy so the receive side sees the new number at once
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			expected_seq_number_out <= 3'h0;
		end else if (clk_en_in) begin
			expected_seq_number_out <= good_packet_in ? expected_seq_number + LSI_SEQ_ONE
				: expected_seq_number;
		end
	end
endmodule : lsi_status_irq
